//--- dps_driver_core.sv
// Display driver reset state and command register file.
// Assumes serial pins synchronous to CLK_I; host keeps its own sequence.
//
// Notes on behaviour
// - Held driver reset gives display off and 132x64 multiplex mode.
// - After reset, segment and common mapping are normal, not remapped.
// - Reset clears the serial shift register, dropping partial words.
// - Reset sets the display start line to memory line zero.
// - Reset loads the column address counter with zero.
// - Reset selects normal common scan direction.
// - Reset loads contrast with 80 hex.
// - Reset selects normal display showing memory, as command A4.
`timescale 1ns/100ps
`default_nettype none
module dps_driver_core
  import dps_pkg::*;
#(
  parameter int unsigned NUM_COLUMNS = COLUMNS
) (
  // Clock and reset
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  input  wire logic       DRIVER_RESET_N_I,
  // Serial command port
  input  wire logic       SCLK_I,
  input  wire logic       SDIN_I,
  input  wire logic       CS_N_I,
  input  wire logic       DC_I,
  // Display state
  output logic            DISPLAY_ON_O,
  output logic [5:0]      MUX_RATIO_O,
  output logic            SEG_REMAP_O,
  output logic            COM_REVERSE_O,
  output logic [5:0]      START_LINE_O,
  output logic [7:0]      COLUMN_O,
  output logic [7:0]      CONTRAST_O,
  output logic            ENTIRE_ON_O,
  output logic            INVERSE_O,
  output logic [7:0]      RAM_DATA_O,
  output logic            RAM_WRITE_O
);
  import dps_pkg::*;

  localparam logic [7:0] COL_MAX = 8'(NUM_COLUMNS - 1);

  // ----------------------------------------------------------------
  // Serial receiver
  // ----------------------------------------------------------------
  // Pin reset and system reset act alike; both are synchronous levels
  wire        clear = RST_I | ~DRIVER_RESET_N_I;

  dps_byte_if rx_bus ();

  dps_serial_rx u_rx (
    .clk   (CLK_I),
    .clear (clear),
    .sclk  (SCLK_I),
    .sdin  (SDIN_I),
    .cs_n  (CS_N_I),
    .dc    (DC_I),
    .out   (rx_bus.src)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  dps_state_t state;
  dps_state_t next_state;
  logic [7:0] pending_op;

  wire  [7:0] b        = rx_bus.byte_val;
  wire        cmd_in   = rx_bus.valid & ~rx_bus.is_data;
  wire        data_in  = rx_bus.valid & rx_bus.is_data;
  wire        in_cmd   = (state == ST_CMD);
  wire        in_arg   = (state == ST_ARG);
  wire        single   = cmd_in & in_cmd;
  wire        argument = cmd_in & in_arg;
  wire        two_byte = (b == OP_CONTRAST) | (b == OP_MUX)
                       | (b == OP_CLOCK)    | (b == OP_OFFSET)
                       | (b == OP_MASTER)   | (b == OP_ADDR_MODE)
                       | (b == OP_COM_CFG)  | (b == OP_PRECHARGE)
                       | (b == OP_DESELECT);
  wire        set_line = single & (b[7:6] == GRP_START);
  wire        set_col_lo = single & (b[7:4] == NIB_COL_LO);
  wire        set_col_hi = single & (b[7:4] == NIB_COL_HI);
  wire        set_contrast = argument & (pending_op == OP_CONTRAST);
  wire        set_mux      = argument & (pending_op == OP_MUX);
  wire  [7:0] col_inc  = (COLUMN_O == COL_MAX) ? COL_RESET
                                               : COLUMN_O + 8'h01;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_CMD: begin
        if (cmd_in && two_byte) begin
          next_state = ST_ARG;
        end
      end
      ST_ARG: begin
        if (cmd_in) begin
          next_state = ST_CMD;
        end
      end
      default: begin
        next_state = ST_CMD;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (clear) begin
      state      <= ST_CMD;
      pending_op <= 8'h00;
    end else begin
      state <= next_state;
      if (single) begin
        pending_op <= b;
      end
    end
  end

  // ----------------------------------------------------------------
  // Single-byte opcode decode
  // ----------------------------------------------------------------
  // One wire per opcode keeps the register processes short
  wire        op_disp_off  = single & (b == OP_DISP_OFF);
  wire        op_disp_on   = single & (b == OP_DISP_ON);
  wire        op_seg_norm  = single & (b == OP_SEG_NORM);
  wire        op_seg_remap = single & (b == OP_SEG_REMAP);
  wire        op_com_norm  = single & (b == OP_COM_NORM);
  wire        op_com_rev   = single & (b == OP_COM_REV);
  wire        op_ram_show  = single & (b == OP_RAM_SHOW);
  wire        op_all_on    = single & (b == OP_ALL_ON);
  wire        op_inv_off   = single & (b == OP_INV_OFF);
  wire        op_inv_on    = single & (b == OP_INV_ON);
  // Ratios below 16 are not valid; such arguments are ignored
  wire        mux_ok       = set_mux & (b[5:4] != 2'h0);
  // Clock, offset, converter, addressing, pin, charge and deselect
  // arguments are consumed and dropped; no output depends on them

  // ----------------------------------------------------------------
  // Panel and mapping flags
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (clear) begin
      DISPLAY_ON_O  <= 1'b0;
      SEG_REMAP_O   <= 1'b0;
      COM_REVERSE_O <= 1'b0;
      ENTIRE_ON_O   <= 1'b0;
      INVERSE_O     <= 1'b0;
    end else begin
      if (op_disp_off)  DISPLAY_ON_O  <= 1'b0;
      if (op_disp_on)   DISPLAY_ON_O  <= 1'b1;
      if (op_seg_norm)  SEG_REMAP_O   <= 1'b0;
      if (op_seg_remap) SEG_REMAP_O   <= 1'b1;
      if (op_com_norm)  COM_REVERSE_O <= 1'b0;
      if (op_com_rev)   COM_REVERSE_O <= 1'b1;
      if (op_ram_show)  ENTIRE_ON_O   <= 1'b0;
      if (op_all_on)    ENTIRE_ON_O   <= 1'b1;
      if (op_inv_off)   INVERSE_O     <= 1'b0;
      if (op_inv_on)    INVERSE_O     <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Display values
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (clear) begin
      MUX_RATIO_O  <= MUX_RESET;
      START_LINE_O <= START_RESET;
      CONTRAST_O   <= CONTRAST_RST;
    end else begin
      if (set_line)     START_LINE_O <= b[5:0];
      if (set_contrast) CONTRAST_O   <= b;
      if (mux_ok)       MUX_RATIO_O  <= b[5:0];
    end
  end

  // ----------------------------------------------------------------
  // Column counter and memory write strobe
  // ----------------------------------------------------------------
  // Page addressing: the column wraps at the end, page is untouched
  wire  [7:0] next_column = data_in    ? col_inc
                          : set_col_lo ? {COLUMN_O[7:4], b[3:0]}
                          : set_col_hi ? {b[3:0], COLUMN_O[3:0]}
                          :              COLUMN_O;

  always_ff @(posedge CLK_I) begin
    if (clear) begin
      COLUMN_O    <= COL_RESET;
      RAM_DATA_O  <= 8'h00;
      RAM_WRITE_O <= 1'b0;
    end else begin
      RAM_WRITE_O <= data_in;
      COLUMN_O    <= next_column;
      if (data_in) RAM_DATA_O <= b;
    end
  end

endmodule : dps_driver_core
`default_nettype wire

//--- dps_pkg.sv
// Constants for the display driver's reset-state and command logic.
// Assumes a single 125 MHz clock domain; no timing counts are needed here.
package dps_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned COLUMNS      = 132;
  localparam logic [7:0]  COL_LAST     = 8'h83;
  localparam logic [5:0]  MUX_RESET    = 6'h3F;  // 132x64 mode
  localparam logic [5:0]  START_RESET  = 6'h00;
  localparam logic [7:0]  COL_RESET    = 8'h00;
  localparam logic [7:0]  CONTRAST_RST = 8'h80;

  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_DISP_OFF   = 8'hAE;
  localparam logic [7:0] OP_DISP_ON    = 8'hAF;
  localparam logic [7:0] OP_SEG_NORM   = 8'hA0;
  localparam logic [7:0] OP_SEG_REMAP  = 8'hA1;
  localparam logic [7:0] OP_COM_NORM   = 8'hC0;
  localparam logic [7:0] OP_COM_REV    = 8'hC8;
  localparam logic [7:0] OP_RAM_SHOW   = 8'hA4;
  localparam logic [7:0] OP_ALL_ON     = 8'hA5;
  localparam logic [7:0] OP_INV_OFF    = 8'hA6;
  localparam logic [7:0] OP_INV_ON     = 8'hA7;
  localparam logic [7:0] OP_CONTRAST   = 8'h81;
  localparam logic [7:0] OP_MUX        = 8'hA8;
  localparam logic [7:0] OP_CLOCK      = 8'hD5;
  localparam logic [7:0] OP_OFFSET     = 8'hD3;
  localparam logic [7:0] OP_MASTER     = 8'hAD;
  localparam logic [7:0] OP_ADDR_MODE  = 8'h20;
  localparam logic [7:0] OP_COM_CFG    = 8'hDA;
  localparam logic [7:0] OP_PRECHARGE  = 8'hD9;
  localparam logic [7:0] OP_DESELECT   = 8'hDB;
  localparam logic [1:0] GRP_START     = 2'h1;   // 0x40..0x7F
  localparam logic [3:0] NIB_COL_LO    = 4'h0;
  localparam logic [3:0] NIB_COL_HI    = 4'h1;

  // ----------------------------------------------------------------
  // Serial word
  // ----------------------------------------------------------------
  localparam int unsigned BYTE_BITS    = 8;
  localparam logic [2:0]  BIT_LAST     = 3'h7;

  typedef enum logic [1:0] {
    ST_CMD = 2'b01,
    ST_ARG = 2'b10
  } dps_state_t;

endpackage : dps_pkg

//--- dps_byte_if.sv
// Byte channel from the serial receiver to the command decoder.
// Assumes both ends share CLK_I.
`timescale 1ns/100ps
`default_nettype none
interface dps_byte_if;
  logic       valid;
  logic       is_data;
  logic [7:0] byte_val;

  modport src (output valid, output is_data, output byte_val);
  modport snk (input valid, input is_data, input byte_val);
endinterface : dps_byte_if
`default_nettype wire

//--- dps_serial_rx.sv
// Serial command receiver: shifts MSB first on rising serial clock.
// Assumes serial pins already synchronous to CLK_I.
`timescale 1ns/100ps
`default_nettype none
module dps_serial_rx
  import dps_pkg::*;
(
  input  wire logic clk,
  input  wire logic clear,
  input  wire logic sclk,
  input  wire logic sdin,
  input  wire logic cs_n,
  input  wire logic dc,
  dps_byte_if.src   out
);
  import dps_pkg::*;

  logic       sclk_q;
  logic [6:0] shift;
  logic [2:0] count;
  wire        rise  = sclk & ~sclk_q & ~cs_n;
  wire        last  = rise & (count == BIT_LAST);

  // ----------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------
  // Deselect also drops a partial word so framing restarts cleanly
  always_ff @(posedge clk) begin
    sclk_q <= sclk;
    if (clear || cs_n) begin
      shift <= 7'h00;
      count <= 3'h0;
    end else if (rise) begin
      shift <= {shift[5:0], sdin};
      count <= count + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (clear) begin
      out.valid    <= 1'b0;
      out.is_data  <= 1'b0;
      out.byte_val <= 8'h00;
    end else begin
      out.valid <= last;
      if (last) begin
        out.byte_val <= {shift, sdin};
        out.is_data  <= dc;
      end
    end
  end

endmodule : dps_serial_rx
`default_nettype wire

//--- dps_driver_core_asserts.sv
// Checker for the driver core: reset state seen at the core's ports.
// Assumes binding onto dps_driver_core; both resets are synchronous.
`timescale 1ns/100ps
`default_nettype none
module dps_driver_core_asserts
  import dps_pkg::*;
(
  input wire logic       CLK_I,
  input wire logic       RST_I,
  input wire logic       DRIVER_RESET_N_I,
  input wire logic       SCLK_I,
  input wire logic       SDIN_I,
  input wire logic       CS_N_I,
  input wire logic       DC_I,
  input wire logic       DISPLAY_ON_O,
  input wire logic [5:0] MUX_RATIO_O,
  input wire logic       SEG_REMAP_O,
  input wire logic       COM_REVERSE_O,
  input wire logic [5:0] START_LINE_O,
  input wire logic [7:0] COLUMN_O,
  input wire logic [7:0] CONTRAST_O,
  input wire logic       ENTIRE_ON_O,
  input wire logic       INVERSE_O,
  input wire logic [7:0] RAM_DATA_O,
  input wire logic       RAM_WRITE_O
);
  // Driver pin reset acts like the core reset
  wire logic rst_any = RST_I || !DRIVER_RESET_N_I;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_reset_disp_off: assert property (rst_any |=> !DISPLAY_ON_O
    && MUX_RATIO_O == MUX_RESET) else $error("display not reset");
  a_reset_map_norm: assert property (rst_any |=> !SEG_REMAP_O)
    else $error("segment map not normal");
  a_reset_no_word: assert property (rst_any |=> !RAM_WRITE_O [*8])
    else $error("stale serial word completed");
  a_reset_start: assert property (rst_any ##1 1 |-> START_LINE_O == 0)
    else $error("start line not zero");
  a_reset_column: assert property (rst_any |=> COLUMN_O == COL_RESET)
    else $error("column not zero");
  a_reset_com_norm: assert property (rst_any |=> !COM_REVERSE_O)
    else $error("common scan reversed");
  a_reset_contrast: assert property ($past(rst_any) |->
    CONTRAST_O == CONTRAST_RST) else $error("contrast not 80");
  a_reset_show_ram: assert property (rst_any |=> !ENTIRE_ON_O
    && !INVERSE_O) else $error("display mode not normal");

  c_write: cover property (RAM_WRITE_O);
  c_on: cover property ($rose(DISPLAY_ON_O));
  c_remap: cover property (SEG_REMAP_O && COM_REVERSE_O);
endmodule : dps_driver_core_asserts
bind dps_driver_core dps_driver_core_asserts u_chk (
  .CLK_I            (CLK_I),
  .RST_I            (RST_I),
  .DRIVER_RESET_N_I (DRIVER_RESET_N_I),
  .SCLK_I           (SCLK_I),
  .SDIN_I           (SDIN_I),
  .CS_N_I           (CS_N_I),
  .DC_I             (DC_I),
  .DISPLAY_ON_O     (DISPLAY_ON_O),
  .MUX_RATIO_O      (MUX_RATIO_O),
  .SEG_REMAP_O      (SEG_REMAP_O),
  .COM_REVERSE_O    (COM_REVERSE_O),
  .START_LINE_O     (START_LINE_O),
  .COLUMN_O         (COLUMN_O),
  .CONTRAST_O       (CONTRAST_O),
  .ENTIRE_ON_O      (ENTIRE_ON_O),
  .INVERSE_O        (INVERSE_O),
  .RAM_DATA_O       (RAM_DATA_O),
  .RAM_WRITE_O      (RAM_WRITE_O)
);
`default_nettype wire

//--- dps_host_model.sv
// Host controller model: serial link, driver reset and panel supply.
// Assumes the driver samples every pin on clk_i.
`timescale 1ns/100ps
`default_nettype none
module dps_host_model (
  input  wire logic clk_i,
  output logic      sclk_o,
  output logic      sdin_o,
  output logic      cs_n_o,
  output logic      dc_o,
  output logic      rst_n_o,
  output logic      panel_en_o
);
  localparam logic [7:0] INIT [24] = '{
    8'hAE, 8'hD5, 8'h80,
    8'hA8, 8'h2F,
    8'hD3, 8'h00, 8'h40,
    8'hAD, 8'h8E,
    8'h20, 8'h02,
    8'hA1, 8'hC8, 8'hDA, 8'h12,
    8'h81, 8'hCF,
    8'hD9, 8'hD2, 8'hDB, 8'h34,
    8'hA4, 8'hA6};
  initial begin
    {sclk_o, sdin_o, dc_o, panel_en_o} = 4'h0;
    cs_n_o = 1'b1;
    rst_n_o = 1'b0;
  end
  // Short word keeps select low, so only a reset can drop it
  task automatic put(input logic [7:0] b, input logic d, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      @(posedge clk_i);
      {cs_n_o, dc_o, sclk_o, sdin_o} <= {1'b0, d, 1'b0, b[i]};
      @(posedge clk_i);
      sclk_o <= 1'b1;
    end
    @(posedge clk_i);
    sclk_o <= 1'b0;
    cs_n_o <= (n < 8) ? 1'b0 : 1'b1;
    sdin_o <= ~sdin_o; // Released line does not keep its level
  endtask : put
  task automatic reset_drv(input int hold);
    @(posedge clk_i);
    {rst_n_o, panel_en_o} <= 2'b00;
    repeat (hold) @(posedge clk_i);
    rst_n_o <= 1'b1;
  endtask : reset_drv
  // Hold stands in for the 100 ms waits
  task automatic power_up(input int hold);
    reset_drv(hold);
    foreach (INIT[k]) put(INIT[k], 1'b0, 8);
    for (int c = 0; c < 132; c++) put(8'h00, 1'b1, 8);
    panel_en_o <= 1'b1;
    repeat (hold) @(posedge clk_i);
    put(8'hAF, 1'b0, 8);
  endtask : power_up
  task automatic power_down(input int hold);
    put(8'hAE, 1'b0, 8);
    panel_en_o <= 1'b0;
    repeat (hold) @(posedge clk_i);
  endtask : power_down
endmodule : dps_host_model
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the driver core with a host model.
// Assumes the core answers one clock after the edge taking the last bit.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dps_pkg::*;
  localparam int HOLD = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, sdin, cs_n, dc, drv_rst_n, panel_en;
  logic disp_on, seg_remap, com_rev, entire_on, inverse, ram_wr;
  logic [5:0] mux, start;
  logic [7:0] col, contrast, ram_data, b;
  int n_errors = 0;
  int compares = 0;
  int seed = 37451;
  always #4 clk = ~clk;
  dps_host_model host (.clk_i(clk), .sclk_o(sclk), .sdin_o(sdin),
    .cs_n_o(cs_n), .dc_o(dc), .rst_n_o(drv_rst_n), .panel_en_o(panel_en));
  dps_driver_core DUT (.CLK_I(clk), .RST_I(rst), .DRIVER_RESET_N_I(drv_rst_n),
    .SCLK_I(sclk), .SDIN_I(sdin), .CS_N_I(cs_n), .DC_I(dc),
    .DISPLAY_ON_O(disp_on), .MUX_RATIO_O(mux), .SEG_REMAP_O(seg_remap),
    .COM_REVERSE_O(com_rev), .START_LINE_O(start), .COLUMN_O(col),
    .CONTRAST_O(contrast), .ENTIRE_ON_O(entire_on), .INVERSE_O(inverse),
    .RAM_DATA_O(ram_data), .RAM_WRITE_O(ram_wr));
  function automatic logic [7:0] exp_col(input int n);
    return 8'(n % COLUMNS);
  endfunction : exp_col
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Write strobe stands one cycle only, so look right after it rises
  task automatic wait_ans();
    @(posedge clk);
    @(negedge clk);
  endtask : wait_ans
  task automatic check_idle();
    check({disp_on, mux}, {1'b0, MUX_RESET});
    check(seg_remap, 1'b0);
    check(start, START_RESET);
    check(col, COL_RESET);
    check(com_rev, 1'b0);
    check(contrast, CONTRAST_RST);
    check({entire_on, inverse}, 2'h0);
  endtask : check_idle
  task automatic end_of_test();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check_idle();
    for (int r = 0; r < 2; r++) begin
      host.power_up(HOLD);
      wait_ans();
      check({disp_on, panel_en}, 2'h3);
      check({mux, contrast}, {6'h2F, 8'hCF});
      check({seg_remap, com_rev, start, col}, {2'h3, 6'h00, 8'h00});
      for (int i = 1; i <= 5; i++) begin
        b = 8'($random(seed));
        host.put(b, 1'b1, 8);
        wait_ans();
        check({ram_wr, ram_data, col}, {1'b1, b, exp_col(i)});
      end
      // Non-reset values so the following reset has work to undo
      host.put(8'h45, 1'b0, 8);
      host.put(8'hA5, 1'b0, 8);
      wait_ans();
      check({entire_on, start}, {1'b1, 6'h05});
      host.put(8'hFF, 1'b0, 5);
      host.reset_drv(HOLD);
      @(negedge clk);
      check_idle();
      host.put(8'hA7, 1'b0, 8);
      wait_ans();
      check(inverse, 1'b1);
    end
    host.power_down(HOLD);
    @(negedge clk);
    check({disp_on, panel_en}, 2'h0);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
